/* File: src/graphics_clock_loop_control.sv */
`default_nettype none
module graphics_clock_loop_control #(
  parameter int SD_W = clock_loop_pkg::SECOND_DIV_WIDTH  // Second divider modulus width
) (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            resetn,
  // Pins from outside the clock domain
  input  wire logic            reference_input,
  input  wire logic            external_feedback_input,
  input  wire logic            video_gate,
  input  wire logic            addr_data_bit3,
  // Configuration bits
  input  wire logic            serial_variant,
  input  wire logic            ref_edge_polarity,
  input  wire logic            divider_chain_feedback_select,
  input  wire logic            external_feedback_select,
  input  wire logic            feedback_edge_polarity,
  input  wire logic            phase_detect_disable_enable,
  input  wire logic            shift_clock_gate_enable,
  input  wire logic [3:0]      latched_address,
  input  wire logic            config_valid,
  input  wire logic [1:0]      output_source_select,
  input  wire logic            aux_clock_level_bit,
  input  wire logic            aux_load_level_bit,
  input  wire logic [3:0]      first_output_divider,
  input  wire logic [SD_W-1:0] second_output_divider,
  // Oscillator and internal divider events
  input  wire logic            osc_clock,
  input  wire logic            internal_feedback_pulse,
  input  wire logic            pixel_group_clock_in,
  input  wire logic            second_divider_clock_in,
  // Outputs
  output logic                 pd_up,
  output logic                 pd_down,
  output logic                 loop_inhibit,
  output logic [1:0]           fb_source,
  output logic [1:0]           clock_mux_select,
  output logic                 diff_clock_out,
  output logic                 pixel_group_clock,
  output logic                 secondary_divided_clock,
  output logic                 secondary_pin_enable,
  output logic [3:0]           first_divider_code
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [5:0]  s1;       // First sync stages: gate, bit3, osc, pix, second, ref
    logic [5:0]  s2;       // Second sync stages
    logic        osc_q;    // Previous oscillator level
    logic        sdiv_q;   // Previous second divider level, for its edge
    logic [1:0]  div;      // Post-scaler counter
    logic        gate;     // Secondary clock allowed
    logic        up;
    logic        down;
    logic        inhibit;
    logic [1:0]  fbs;
    logic [1:0]  mux;
    logic        diff;
    logic        pix;
    logic        sec;
    logic        sec_en;
    logic [3:0]  first_div; // First divider code
  } st_t;
  st_t st;
  st_t next_st;

  logic ref_pulse;   // Chosen reference edge
  logic ext_pulse;   // Chosen external feedback edge
  logic fb_pulse;    // Selected feedback event
  logic vg_s, bit3_s, osc_s, pix_s, sdiv_s, ref_s;  // Synchronised pin levels

  // Reference edge: rising when the polarity bit is one
  edge_sel u_ref (
    .mclk   (mclk),
    .resetn (resetn),
    .din    (reference_input),
    .rising (ref_edge_polarity),
    .pulse  (ref_pulse)
  );
  // External feedback: rising when the polarity bit is zero
  edge_sel u_ext (
    .mclk   (mclk),
    .resetn (resetn),
    .din    (external_feedback_input),
    .rising (~feedback_edge_polarity),
    .pulse  (ext_pulse)
  );

  assign vg_s   = st.s2[0];
  assign bit3_s = st.s2[1];
  assign osc_s  = st.s2[2];
  assign pix_s  = st.s2[3];
  assign sdiv_s = st.s2[4];
  assign ref_s  = st.s2[5];

  // ---------------------------------------------------------------
  // Feedback selection: external wins over chain, chain over internal
  // ---------------------------------------------------------------
  always_comb begin
    if (external_feedback_select) begin
      fb_pulse = ext_pulse;
    end else if (divider_chain_feedback_select) begin
      // Own edge register: the gated output sits low while stopped
      fb_pulse = sdiv_s & ~st.sdiv_q;
    end else begin
      fb_pulse = internal_feedback_pulse;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st    = st;
    next_st.s1 = {reference_input, second_divider_clock_in, pixel_group_clock_in,
                  osc_clock, addr_data_bit3, video_gate};
    next_st.s2 = st.s1;
    next_st.osc_q = osc_s;
    next_st.sdiv_q = sdiv_s;
    if (osc_s & ~st.osc_q) begin
      next_st.div = st.div + 2'h1;
    end
    // Inhibit: serial uses gate pin, parallel needs address 15
    if (serial_variant) begin
      next_st.inhibit = phase_detect_disable_enable & vg_s;
    end else begin
      next_st.inhibit = phase_detect_disable_enable &
                        (latched_address == clock_loop_pkg::PDIS_ADDR) & bit3_s;
    end
    // Detector holds still while inhibited
    if (st.inhibit) begin
      next_st.up   = 1'b0;
      next_st.down = 1'b0;
    end else begin
      next_st.up   = ref_pulse & ~fb_pulse;
      next_st.down = fb_pulse & ~ref_pulse;
    end
    if (external_feedback_select) begin
      next_st.fbs = clock_loop_pkg::FB_EXTERNAL;
    end else if (divider_chain_feedback_select) begin
      next_st.fbs = clock_loop_pkg::FB_CHAIN;
    end else begin
      next_st.fbs = clock_loop_pkg::FB_INTERNAL;
    end
    // Configuration takes effect once programmed
    if (config_valid) begin
      next_st.mux       = output_source_select;
      next_st.first_div = first_output_divider;
    end
    // Post-scaler and static test
    case (next_st.mux)
      clock_loop_pkg::SRC_VCO:      next_st.diff = osc_s;
      clock_loop_pkg::SRC_VCO_DIV2: next_st.diff = st.div[0];
      clock_loop_pkg::SRC_VCO_DIV4: next_st.diff = st.div[1];
      clock_loop_pkg::SRC_STATIC:   next_st.diff = aux_clock_level_bit;
      default:                      next_st.diff = osc_s;
    endcase
    if (!config_valid) begin
      // Reference passes straight through until programmed
      next_st.diff = ref_s;
    end
    next_st.pix = (next_st.mux == clock_loop_pkg::SRC_STATIC) ?
                  aux_load_level_bit : pix_s;
    // Gate may only change while pixel clock is low
    if (!pix_s) begin
      next_st.gate = ~shift_clock_gate_enable | vg_s;
    end
    // Modulus one mirrors pixel clock; gated low when stopped
    if (!st.gate) begin
      next_st.sec = 1'b0;
    end else if (second_output_divider == SD_W'(clock_loop_pkg::SECOND_DIV_ONE)) begin
      next_st.sec = pix_s;
    end else begin
      next_st.sec = sdiv_s;
    end
    // Pin is an output except in reset, which clears its enable; in chain mode it carries the second divider
    next_st.sec_en = 1'b1;
  end

  // Reset: mux selects the oscillator direct, first divider code one
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st      <= '0;
      st.mux  <= clock_loop_pkg::SRC_VCO;
      st.first_div <= clock_loop_pkg::FIRST_DIV_RESET;
      st.gate <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign pd_up                   = st.up;
  assign pd_down                 = st.down;
  assign loop_inhibit            = st.inhibit;
  assign fb_source               = st.fbs;
  assign clock_mux_select        = st.mux;
  assign diff_clock_out          = st.diff;
  assign pixel_group_clock       = st.pix;
  assign secondary_divided_clock = st.sec;
  assign secondary_pin_enable    = st.sec_en;
  assign first_divider_code      = st.first_div;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  inhibit_quiet_a: assert property (st.inhibit |=> !st.up && !st.down)
    else $error("detector active while inhibited");
  stop_low_a: assert property (!st.gate |=> !st.sec)
    else $error("secondary clock not held low");
  gate_timing_a: assert property ($changed(st.gate) |-> !$past(pix_s))
    else $error("gate changed while pixel clock high");
  static_pix_a: assert property ((next_st.mux == clock_loop_pkg::SRC_STATIC)
    |=> st.pix == $past(aux_load_level_bit))
    else $error("static pixel level wrong");
  ext_sel_a: assert property (external_feedback_select |=>
    st.fbs == clock_loop_pkg::FB_EXTERNAL)
    else $error("external feedback not selected");
  chain_sel_a: assert property (!external_feedback_select &&
    divider_chain_feedback_select |=> st.fbs == clock_loop_pkg::FB_CHAIN)
    else $error("chain feedback not selected");
  serial_inh_a: assert property (serial_variant && phase_detect_disable_enable
    && vg_s |=> st.inhibit)
    else $error("serial inhibit missing");
  par_inh_a: assert property (!serial_variant && latched_address !=
    clock_loop_pkg::PDIS_ADDR |=> !st.inhibit)
    else $error("parallel inhibit without address");
endmodule
`default_nettype wire

/* File: src/clock_loop_pkg.sv */
`default_nettype none
package clock_loop_pkg;

  // ---------------------------------------------------------------
  // Output source select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SRC_VCO      = 2'h0;  // Oscillator direct
  localparam logic [1:0] SRC_VCO_DIV2 = 2'h1;  // Oscillator / 2
  localparam logic [1:0] SRC_VCO_DIV4 = 2'h2;  // Oscillator / 4
  localparam logic [1:0] SRC_STATIC   = 2'h3;  // Static test, aux level

  // ---------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [3:0] FIRST_DIV_RESET  = 4'h1;  // Divide by four
  localparam logic [3:0] PDIS_ADDR        = 4'hf;  // Address that arms disable
  localparam int         SECOND_DIV_WIDTH = 9;     // Second divider modulus bits
  localparam logic [8:0] SECOND_DIV_ONE   = 9'h001; // Modulus one: copy pixel clock

  // ---------------------------------------------------------------
  // Detector input selection
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {FB_INTERNAL, FB_CHAIN, FB_EXTERNAL} fb_src_t;

endpackage
`default_nettype wire

/* File: src/edge_sel.sv */
`default_nettype none
// Synchroniser plus selectable-edge pulse detector
module edge_sel (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Signal and edge choice
  input  wire logic din,
  input  wire logic rising,
  // One-cycle edge pulse
  output logic      pulse
);
  typedef struct packed {
    logic s1;    // First sync stage, read only by s2
    logic s2;    // Second sync stage
    logic s3;    // Previous level
    logic pulse; // Registered edge
  } es_t;
  es_t st;
  es_t next_st;

  // Edge detect on synchronised copy only
  always_comb begin
    next_st       = st;
    next_st.s1    = din;
    next_st.s2    = st.s1;
    next_st.s3    = st.s2;
    next_st.pulse = rising ? (st.s2 & ~st.s3) : (~st.s2 & st.s3);
  end

  // State register; reset clears the whole chain at once
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign pulse = st.pulse;
endmodule
`default_nettype wire

/* File: testbench/clock_source_model.sv */
`default_nettype none
// ---------------------------------------------------------------
// Oscillator and divider side: free-running clock levels
// ---------------------------------------------------------------
module clock_source_model (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Clock levels seen by the control block
  output logic      osc_clock,
  output logic      pixel_group_clock_in,
  output logic      second_divider_clock_in,
  output logic      reference_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt;  // Ripple of divided phases

  // Phases from cnt[2] up keep every edge well above the two-flop sync delay; osc toggles every cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 5'h00;
    end else begin
      cnt <= cnt + 5'h01;
    end
  end
  // Loop gains are set by the host elsewhere; these levels stand for a settled loop
  assign osc_clock               = cnt[0];
  assign pixel_group_clock_in    = cnt[2];
  assign second_divider_clock_in = cnt[3];
  assign reference_input         = cnt[4];
endmodule
`default_nettype wire

/* File: testbench/graphics_clock_loop_control_bench.sv */
`default_nettype none
module graphics_clock_loop_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic mclk = 1'b0, resetn = 1'b0;
  logic ref_in, ext_fb, video_gate = 1'b1, addr_data_bit3 = 1'b0;
  logic serial_variant = 1'b1, ref_pol = 1'b1, chain_sel = 1'b0, ext_sel = 1'b0;
  logic fb_pol = 1'b0, pd_en = 1'b0, gate_en = 1'b0, config_valid = 1'b0;
  logic aux_clk = 1'b0, aux_load = 1'b0, int_fb = 1'b0;
  logic [3:0] latched_address = 4'h0, first_div = 4'h1;
  logic [1:0] src_sel = 2'h0;
  logic [8:0] second_div = 9'h001;
  logic osc, pix_in, sec_in;
  logic pd_up, pd_down, loop_inhibit, diff_clock_out, pixel_group_clock;
  logic secondary_divided_clock, secondary_pin_enable;
  logic [1:0] fb_source, clock_mux_select;
  logic [3:0] first_divider_code;
  int err_count = 0, checks = 0, cycles = 0;

  always #25 mclk = ~mclk;  // 20 MHz
  assign ext_fb = ref_in;   // External counter output loops back in phase

  clock_source_model clock_source_model_inst (.mclk(mclk), .resetn(resetn),
    .osc_clock(osc), .pixel_group_clock_in(pix_in),
    .second_divider_clock_in(sec_in), .reference_input(ref_in));

  graphics_clock_loop_control graphics_clock_loop_control_inst (
    .mclk(mclk), .resetn(resetn), .reference_input(ref_in),
    .external_feedback_input(ext_fb), .video_gate(video_gate),
    .addr_data_bit3(addr_data_bit3), .serial_variant(serial_variant),
    .ref_edge_polarity(ref_pol), .divider_chain_feedback_select(chain_sel),
    .external_feedback_select(ext_sel), .feedback_edge_polarity(fb_pol),
    .phase_detect_disable_enable(pd_en), .shift_clock_gate_enable(gate_en),
    .latched_address(latched_address), .config_valid(config_valid),
    .output_source_select(src_sel), .aux_clock_level_bit(aux_clk),
    .aux_load_level_bit(aux_load), .first_output_divider(first_div),
    .second_output_divider(second_div), .osc_clock(osc), .internal_feedback_pulse(int_fb),
    .pixel_group_clock_in(pix_in), .second_divider_clock_in(sec_in),
    .pd_up(pd_up), .pd_down(pd_down), .loop_inhibit(loop_inhibit),
    .fb_source(fb_source), .clock_mux_select(clock_mux_select),
    .diff_clock_out(diff_clock_out), .pixel_group_clock(pixel_group_clock),
    .secondary_divided_clock(secondary_divided_clock),
    .secondary_pin_enable(secondary_pin_enable), .first_divider_code(first_divider_code));

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Lets n edges pass, then samples 1 ns after the last edge has settled
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Rising edges of the differential output over 64 settled samples
  task automatic count_rises(output int n);
    logic prev;
    n = 0;
    prev = diff_clock_out;
    repeat (64) begin
      wait_n(1);
      n += int'(diff_clock_out & ~prev);
      prev = diff_clock_out;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Cycle ceiling so a hang still reaches the report
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Reference period is 32 cycles, so 64 samples hold two rises
  task automatic sc_reset();
    int n;
    wait_n(5);
    chk(clock_mux_select, clock_loop_pkg::SRC_VCO);
    chk(first_divider_code, clock_loop_pkg::FIRST_DIV_RESET);
    @(posedge mclk) resetn <= 1'b1;
    wait_n(4);
    chk(first_divider_code, clock_loop_pkg::FIRST_DIV_RESET);
    count_rises(n);
    chk(8'(n), 8'h02);
  endtask

  // Priority: external over chain over internal
  task automatic sc_feedback();
    @(posedge mclk) chain_sel <= 1'b1;
    wait_n(3);
    chk(fb_source, 2'h1);
    chk(secondary_pin_enable, 1'b1);
    @(posedge mclk) ext_sel <= 1'b1;
    wait_n(3);
    chk(fb_source, 2'h2);
    @(posedge mclk) {ext_sel, chain_sel} <= 2'b00;
    wait_n(3);
    chk(fb_source, 2'h0);
  endtask

  task automatic sc_inhibit();
    @(posedge mclk) {pd_en, serial_variant, video_gate} <= 3'b111;
    wait_n(6);
    chk(loop_inhibit, 1'b1);
    @(posedge mclk) {serial_variant, latched_address, addr_data_bit3} <= 6'b0_1110_1;
    wait_n(6);
    chk(loop_inhibit, 1'b0);
    @(posedge mclk) latched_address <= clock_loop_pkg::PDIS_ADDR;
    wait_n(6);
    chk(loop_inhibit, 1'b1);
    @(posedge mclk) pd_en <= 1'b0;
    wait_n(6);
    chk(loop_inhibit, 1'b0);
  endtask

  // Static test levels: every combination of the two bits
  task automatic sc_static();
    int n;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk) {config_valid, src_sel, aux_clk, aux_load} <= {3'b111, 2'(i)};
      wait_n(4);
      chk(clock_mux_select, clock_loop_pkg::SRC_STATIC);
      chk({diff_clock_out, pixel_group_clock}, 8'(i));
    end
    // Oscillator toggles each cycle: 32, 16 and 8 rises in 64 samples
    for (int m = 0; m < 3; m++) begin
      @(posedge mclk) src_sel <= 2'(m);
      wait_n(8);
      count_rises(n);
      chk(8'(n), 8'(32 >> m));
    end
    @(posedge mclk) {src_sel, first_div} <= {clock_loop_pkg::SRC_VCO_DIV2, 4'h5};
    wait_n(4);
    chk(clock_mux_select, clock_loop_pkg::SRC_VCO_DIV2);
    chk(first_divider_code, 4'h5);
  endtask

  task automatic sc_gate();
    @(posedge mclk) {gate_en, src_sel, second_div} <= {1'b1, clock_loop_pkg::SRC_VCO, 9'h001};
    @(posedge mclk) video_gate <= 1'b0;
    wait_n(14);
    for (int i = 0; i < 20; i++) begin
      chk(secondary_divided_clock, 1'b0);
      wait_n(1);
    end
    @(posedge mclk) video_gate <= 1'b1;
    wait_n(14);
    for (int i = 0; i < 20; i++) begin
      chk(secondary_divided_clock, pixel_group_clock);
      wait_n(1);
    end
  endtask

  // Detector direction for both edge choices, then silenced by the gate pin;
  // a pin edge shows on the detector outputs four samples later
  task automatic sc_detector();
    logic [5:0] h;
    logic       rise;
    logic       fall;
    h = '0;
    for (int m = 0; m < 3; m++) begin
      @(posedge mclk) {ext_sel, ref_pol, fb_pol, pd_en, serial_variant, gate_en} <=
        {1'b1, m != 1, m != 1, m == 2, 1'b1, 1'b0};
      wait_n(8);
      repeat (6) begin
        h = {h[4:0], ref_in};
        wait_n(1);
      end
      repeat (64) begin
        h = {h[4:0], ref_in};
        rise = h[4] & ~h[5];
        fall = h[5] & ~h[4];
        chk(pd_up, (m == 2) ? 1'b0 : ((m == 0) ? rise : fall));
        chk(pd_down, (m == 2) ? 1'b0 : ((m == 0) ? fall : rise));
        wait_n(1);
      end
    end
    @(posedge mclk) pd_en <= 1'b0;
  endtask

  // Chain feedback: second divider on the pin three samples late, its rises
  // (period 16) pull the detector down, reference rises (period 32) push up
  task automatic sc_chain();
    logic [3:0] h;
    int         ups;
    int         downs;
    h = '0;
    ups = 0;
    downs = 0;
    @(posedge mclk) {ext_sel, pd_en, chain_sel, second_div} <= {3'b001, 9'h002};
    wait_n(8);
    repeat (3) begin
      h = {h[2:0], sec_in};
      wait_n(1);
    end
    repeat (64) begin
      h = {h[2:0], sec_in};
      chk(secondary_divided_clock, h[3]);
      ups += int'(pd_up);
      downs += int'(pd_down);
      wait_n(1);
    end
    chk(8'(downs), 8'h04);
    chk(8'(ups), 8'h02);
  endtask

  initial begin
    sc_reset();
    sc_feedback();
    sc_inhibit();
    sc_static();
    sc_gate();
    sc_detector();
    sc_chain();
    end_of_test();
  end
endmodule
`default_nettype wire
